// file: src/dpr_pkg.sv
// Shared constants and types for the synchronous dual-port burst RAM
package dpr_pkg;

	// ==========================================================
	// Array organisation
	localparam int DPR_AW_16K = 14;
	localparam int DPR_AW_32K = 15;
	localparam int DPR_AW_64K = 16;
	localparam int DPR_W_X16  = 16;
	localparam int DPR_W_X18  = 18;
	localparam int DPR_AW_DEF = DPR_AW_64K;
	localparam int DPR_W_DEF  = DPR_W_X18;
	localparam int DPR_LANES  = 2;

	// ==========================================================
	// Field positions within a lane vector
	localparam int DPR_LOWER_LANE = 0;
	localparam int DPR_UPPER_LANE = 1;

	// ==========================================================
	// Modes and reset values
	localparam logic DPR_MODE_FLOW = 1'b0;
	localparam logic DPR_MODE_PIPE = 1'b1;
	localparam int   DPR_CNT_RST   = 0;
	localparam logic DPR_OE_RST    = 1'b0;

	typedef enum logic {
		DPR_PWR_DOWN,
		DPR_PWR_UP
	} dpr_pwr_t;

	localparam dpr_pwr_t DPR_PWR_RST = DPR_PWR_DOWN;

endpackage

// file: src/dpr_mem.sv
// Shared storage array with two access ports and registered read data
`timescale 1ns/100ps

module dpr_mem #(
	parameter int AW = dpr_pkg::DPR_AW_DEF,
	parameter int W  = dpr_pkg::DPR_W_DEF
) (
	input  wire logic                          clk,
	input  wire logic                          a_en,
	input  wire logic [dpr_pkg::DPR_LANES-1:0] a_we,
	input  wire logic [AW-1:0]                 a_addr,
	input  wire logic [W-1:0]                  a_wdata,
	output logic      [W-1:0]                  a_rdata,
	input  wire logic                          b_en,
	input  wire logic [dpr_pkg::DPR_LANES-1:0] b_we,
	input  wire logic [AW-1:0]                 b_addr,
	input  wire logic [W-1:0]                  b_wdata,
	output logic      [W-1:0]                  b_rdata
);
	import dpr_pkg::*;

	localparam int LW = W / 2;

	logic [W-1:0] mem [2**AW];

	// ==========================================================
	// Access
	// One process serves both ports; on a same-address double write the
	// second port lands last, which is as good as any undefined result.
	always_ff @(posedge clk) begin
		if (a_en) begin
			a_rdata <= mem[a_addr];
		end
		if (b_en) begin
			b_rdata <= mem[b_addr];
		end
		if (a_en && a_we[DPR_LOWER_LANE]) begin
			mem[a_addr][LW-1:0] <= a_wdata[LW-1:0];
		end
		if (a_en && a_we[DPR_UPPER_LANE]) begin
			mem[a_addr][W-1:LW] <= a_wdata[W-1:LW];
		end
		if (b_en && b_we[DPR_LOWER_LANE]) begin
			mem[b_addr][LW-1:0] <= b_wdata[LW-1:0];
		end
		if (b_en && b_we[DPR_UPPER_LANE]) begin
			mem[b_addr][W-1:LW] <= b_wdata[W-1:LW];
		end
	end

endmodule

// file: src/dpr_burst_cnt.sv
// Burst address counter of one port
`timescale 1ns/100ps

module dpr_burst_cnt #(
	parameter int AW = dpr_pkg::DPR_AW_DEF
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          addr_load_strobe_n,
	input  wire logic          burst_count_enable_n,
	input  wire logic          burst_count_clear_n,
	input  wire logic [AW-1:0] ext_addr,
	output logic      [AW-1:0] acc_addr
);
	import dpr_pkg::*;

	typedef struct packed {
		logic [AW-1:0] cnt;
	} dpr_cnt_t;

	dpr_cnt_t s;
	dpr_cnt_t next_s;

	// ==========================================================
	// Address choice
	// Clear beats load, load beats count; a free-running sum wraps to zero.
	always_comb begin
		if (!burst_count_clear_n) begin
			acc_addr = AW'(DPR_CNT_RST);
		end else if (!addr_load_strobe_n) begin
			acc_addr = ext_addr;
		end else if (!burst_count_enable_n) begin
			acc_addr = AW'(s.cnt + 1'b1);
		end else begin
			acc_addr = s.cnt;
		end
		next_s.cnt = acc_addr;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s.cnt <= AW'(DPR_CNT_RST);
		end else begin
			s <= next_s;
		end
	end

endmodule

// file: src/dpr_top.sv
// Synchronous dual-port RAM with burst counters and selectable output latency
`timescale 1ns/100ps

// Overview of operation
// - Two ports access any word concurrently
// - Depth 16K/32K/64K, width 16 or 18
// - Inputs registered on rising clock edge
// - Pipelined mode adds one output register stage
// - Latency mode chosen per port by input
// - Each port owns a burst address counter
// - Write completes within one clock cycle
// - Either select inactive powers the port down
// - Selected only when both selects active
// - Pipelined outputs return one cycle after reselect
// - Counting ignores external address pins
// - Load strobe uses and loads external address
// - Count enable increments counter every edge
// - One word per cycle at next address
// - Counter spans array and wraps to zero
// - Counter clear resets counter
// - Clear dominates; count ignored during load/clear
// - Lane selects gate writes and read drive
module dpr_top #(
	parameter int AW = dpr_pkg::DPR_AW_DEF,
	parameter int W  = dpr_pkg::DPR_W_DEF
) (
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic [AW-1:0]                 left_addr,
	input  wire logic                          left_addr_load_strobe_n,
	input  wire logic                          left_burst_count_enable_n,
	input  wire logic                          left_burst_count_clear_n,
	input  wire logic                          left_active_low_select_n,
	input  wire logic                          left_active_high_select,
	input  wire logic                          left_write_n,
	input  wire logic                          left_output_enable_n,
	input  wire logic                          left_lower_lane_select_n,
	input  wire logic                          left_upper_lane_select_n,
	input  wire logic                          left_output_latency_select,
	input  wire logic [W-1:0]                  left_data_in,
	output logic      [W-1:0]                  left_data_out,
	output logic      [dpr_pkg::DPR_LANES-1:0] left_data_oe,
	output logic                               left_powered_down,
	input  wire logic [AW-1:0]                 right_addr,
	input  wire logic                          right_addr_load_strobe_n,
	input  wire logic                          right_burst_count_enable_n,
	input  wire logic                          right_burst_count_clear_n,
	input  wire logic                          right_active_low_select_n,
	input  wire logic                          right_active_high_select,
	input  wire logic                          right_write_n,
	input  wire logic                          right_output_enable_n,
	input  wire logic                          right_lower_lane_select_n,
	input  wire logic                          right_upper_lane_select_n,
	input  wire logic                          right_output_latency_select,
	input  wire logic [W-1:0]                  right_data_in,
	output logic      [W-1:0]                  right_data_out,
	output logic      [dpr_pkg::DPR_LANES-1:0] right_data_oe,
	output logic                               right_powered_down
);
	import dpr_pkg::*;

	localparam int NP = 2;
	localparam int LN = DPR_LANES;

	// ==========================================================
	// Per-port state
	typedef struct packed {
		logic [AW-1:0] addr;
		logic          load_n;
		logic          count_n;
		logic          clear_n;
		logic          sel;
		logic          write_n;
		logic          lower_n;
		logic          upper_n;
		logic          oe_n;
		logic          pipe;
		logic [W-1:0]  din;
	} dpr_cap_t;

	typedef struct packed {
		dpr_cap_t      cap;
		dpr_pwr_t      pwr;
		logic          acc_rd;
		logic [LN-1:0] acc_lane;
		logic [W-1:0]  pipe_data;
		logic          pipe_rd;
		logic [LN-1:0] pipe_lane;
		logic [W-1:0]  out_data;
		logic [LN-1:0] out_oe;
	} dpr_port_t;

	// Lane enables of a selected port; shared by write strobes and read drive
	function automatic logic [LN-1:0] lane_on(input logic sel, input logic lower_n, input logic upper_n);
		lane_on = {sel & ~upper_n, sel & ~lower_n};
	endfunction

	// Both selects must agree; either one alone deselects the port
	function automatic logic port_sel(input logic sel_n, input logic sel);
		port_sel = ~sel_n & sel;
	endfunction

	// Byte-lane write strobes of one captured cycle
	function automatic logic [LN-1:0] write_lanes(input dpr_cap_t c);
		write_lanes = c.write_n ? '0 : lane_on(c.sel, c.lower_n, c.upper_n);
	endfunction

	// ==========================================================
	// Pin gathering
	// Both ports are packed into arrays so one generate loop serves them
	logic [NP-1:0][AW-1:0] p_addr;
	logic [NP-1:0]         p_load_n;
	logic [NP-1:0]         p_count_n;
	logic [NP-1:0]         p_clear_n;
	logic [NP-1:0]         p_sel_n;
	logic [NP-1:0]         p_sel;
	logic [NP-1:0]         p_write_n;
	logic [NP-1:0]         p_oe_n;
	logic [NP-1:0]         p_lower_n;
	logic [NP-1:0]         p_upper_n;
	logic [NP-1:0]         p_pipe;
	logic [NP-1:0][W-1:0]  p_din;

	assign p_addr    = {right_addr, left_addr};
	assign p_load_n  = {right_addr_load_strobe_n, left_addr_load_strobe_n};
	assign p_count_n = {right_burst_count_enable_n, left_burst_count_enable_n};
	assign p_clear_n = {right_burst_count_clear_n, left_burst_count_clear_n};
	assign p_sel_n   = {right_active_low_select_n, left_active_low_select_n};
	assign p_sel     = {right_active_high_select, left_active_high_select};
	assign p_write_n = {right_write_n, left_write_n};
	assign p_oe_n    = {right_output_enable_n, left_output_enable_n};
	assign p_lower_n = {right_lower_lane_select_n, left_lower_lane_select_n};
	assign p_upper_n = {right_upper_lane_select_n, left_upper_lane_select_n};
	assign p_pipe    = {right_output_latency_select, left_output_latency_select};
	assign p_din     = {right_data_in, left_data_in};

	wire [NP-1:0][AW-1:0] m_addr;
	wire [NP-1:0]         m_en;
	wire [NP-1:0][LN-1:0] m_we;
	wire [NP-1:0][W-1:0]  m_wdata;
	wire [NP-1:0][W-1:0]  m_rdata;
	wire [NP-1:0][W-1:0]  o_data;
	wire [NP-1:0][LN-1:0] o_oe;
	wire [NP-1:0]         o_down;

	// ==========================================================
	// Port pipelines
	// Timing of one access, counted in edges from the pin capture:
	//   edge 0  pins land in the capture register
	//   edge 1  array read or write at the counter's address
	//   edge 2  flow-through word reaches the output register
	//   edge 3  pipelined word reaches the output register
	// Output enable is taken from the capture just before the output edge,
	// and so is the latency choice. A change of latency in mid-stream can
	// therefore drop or repeat one read; switch modes on an idle port.
	// The counter follows its strobes even while the port is deselected,
	// so a burst can be parked there and resumed without a reload.
	for (genvar g = 0; g < NP; g++) begin : g_port
		dpr_port_t     s;
		dpr_port_t     next_s;
		logic [W-1:0]  src_data;
		logic          src_rd;
		logic [LN-1:0] src_lane;

		// Counter sits behind the captured address, not the raw pins
		dpr_burst_cnt #(
			.AW (AW)
		) u_cnt (
			.clk                  (clk),
			.reset                (reset),
			.addr_load_strobe_n   (s.cap.load_n),
			.burst_count_enable_n (s.cap.count_n),
			.burst_count_clear_n  (s.cap.clear_n),
			.ext_addr             (s.cap.addr),
			.acc_addr             (m_addr[g])
		);

		// Deselected ports leave the array idle, which is the power saving
		assign m_en[g]    = s.cap.sel;
		assign m_we[g]    = write_lanes(s.cap);
		assign m_wdata[g] = s.cap.din;
		assign o_data[g]  = s.out_data;
		assign o_oe[g]    = s.out_oe;
		assign o_down[g]  = (s.pwr == DPR_PWR_DOWN);

		always_comb begin
			next_s = s;
			next_s.cap.addr    = p_addr[g];
			next_s.cap.load_n  = p_load_n[g];
			next_s.cap.count_n = p_count_n[g];
			next_s.cap.clear_n = p_clear_n[g];
			next_s.cap.sel     = port_sel(p_sel_n[g], p_sel[g]);
			next_s.cap.write_n = p_write_n[g];
			next_s.cap.lower_n = p_lower_n[g];
			next_s.cap.upper_n = p_upper_n[g];
			next_s.cap.oe_n    = p_oe_n[g];
			next_s.cap.pipe    = p_pipe[g];
			// Write data only matters on a selected cycle; holding it otherwise
			// keeps a parked port's capture register quiet
			if (port_sel(p_sel_n[g], p_sel[g])) begin
				next_s.cap.din = p_din[g];
			end

			// Power state trails the captured select by one edge, so a single
			// deselected cycle is enough to park the port, and a single
			// selected cycle wakes it again
			case (s.pwr)
				DPR_PWR_UP: begin
					if (!s.cap.sel) begin
						next_s.pwr = DPR_PWR_DOWN;
					end
				end
				DPR_PWR_DOWN: begin
					if (s.cap.sel) begin
						next_s.pwr = DPR_PWR_UP;
					end
				end
				default: begin
					next_s.pwr = DPR_PWR_RST;
				end
			endcase

			// Access stage: read data lands in the array's output register
			next_s.acc_rd   = s.cap.sel & s.cap.write_n;
			next_s.acc_lane = lane_on(s.cap.sel, s.cap.lower_n, s.cap.upper_n);

			// Extra register used only in pipelined mode; it loads only behind
			// a real read, so the word it holds always pairs with pipe_rd
			if (s.acc_rd) begin
				next_s.pipe_data = m_rdata[g];
			end
			next_s.pipe_rd   = s.acc_rd;
			next_s.pipe_lane = s.acc_lane;

			// A deselected access carries no read, so after reselect the
			// pipelined path stays dark for one more cycle
			if (s.cap.pipe == DPR_MODE_PIPE) begin
				src_data = s.pipe_data;
				src_rd   = s.pipe_rd;
				src_lane = s.pipe_lane;
			end else begin
				src_data = m_rdata[g];
				src_rd   = s.acc_rd;
				src_lane = s.acc_lane;
			end

			// Output enable is the live sampled level, not the one of the access
			next_s.out_oe = (src_rd && !s.cap.oe_n) ? src_lane : '0;
			if (src_rd) begin
				next_s.out_data = src_data;
			end
		end

		always_ff @(posedge clk) begin
			if (reset) begin
				// The array is not cleared; control state, the capture, pipeline and
				// output registers all return to idle
				s        <= '0;
				s.pwr    <= DPR_PWR_RST;
				s.out_oe <= {LN{DPR_OE_RST}};
			end else begin
				s <= next_s;
			end
		end
	end

	// ==========================================================
	// Shared array
	// Both ports run every cycle with no arbitration; same-address double
	// writes are left to the hosts to avoid.
	dpr_mem #(
		.AW (AW),
		.W  (W)
	) u_mem (
		.clk     (clk),
		.a_en    (m_en[0]),
		.a_we    (m_we[0]),
		.a_addr  (m_addr[0]),
		.a_wdata (m_wdata[0]),
		.a_rdata (m_rdata[0]),
		.b_en    (m_en[1]),
		.b_we    (m_we[1]),
		.b_addr  (m_addr[1]),
		.b_wdata (m_wdata[1]),
		.b_rdata (m_rdata[1])
	);

	// ==========================================================
	// Pin outputs, each straight from a port register
	assign left_data_out      = o_data[0];
	assign left_data_oe       = o_oe[0];
	assign left_powered_down  = o_down[0];
	assign right_data_out     = o_data[1];
	assign right_data_oe      = o_oe[1];
	assign right_powered_down = o_down[1];

endmodule

// file: dv/dpr_host.sv
// Host-side model that drives the pins of one port of the dual-port RAM
`timescale 1ns/100ps
module dpr_host #(
	parameter int AW = 16,
	parameter int W  = 18
) (
	input  wire logic            clk,
	input  wire logic            reset,
	input  wire logic [AW+W+9:0] req,
	output logic      [AW+W+9:0] pins
);
	// ====================
	// Pin driver
	// Deselected, strobes inactive, flow-through latency
	localparam logic [9:0] IDLE = 10'h1EF;
	// Pins move only just after an edge, so the device never sees them mid-change
	always @(posedge clk) begin
		if (reset)
			pins <= {{(AW+W){1'b0}}, IDLE};
		// A released data bus must not keep showing the last written word
		else if (req[5])
			pins <= {req[AW+W+9:W+10], ~pins[W+9:10], req[9:0]};
		else
			pins <= req;
	end
endmodule

// file: dv/dpr_top_chk.sv
// Concurrent checks on the left port of the dual-port burst RAM
`timescale 1ns/100ps
module dpr_top_chk (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       left_active_low_select_n,
	input wire logic       left_active_high_select,
	input wire logic       left_write_n,
	input wire logic       left_output_enable_n,
	input wire logic       left_lower_lane_select_n,
	input wire logic       left_upper_lane_select_n,
	input wire logic       left_output_latency_select,
	input wire logic [1:0] left_data_oe,
	input wire logic       left_powered_down
);
	import dpr_pkg::*;
	logic sel, any, rd, m, oen;
	assign sel = !left_active_low_select_n && left_active_high_select;
	assign any = sel && left_write_n;
	assign rd  = any && !left_lower_lane_select_n && !left_upper_lane_select_n;
	assign m   = left_output_latency_select == DPR_MODE_PIPE;
	assign oen = left_output_enable_n;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ====================
	// Power-down, up to three edges of lag allowed
	property p_pd_on; (!sel)[*3] |=> left_powered_down; endproperty
	a_pd_on: assert property (p_pd_on) else $error("port not powered down");
	property p_pd_off; sel[*3] |=> !left_powered_down; endproperty
	a_pd_off: assert property (p_pd_off) else $error("selected port powered down");
	// ====================
	// Read latency and drive gating
	property p_flow_rd; (rd && !m) ##1 (!oen && !m) |-> ##2 left_data_oe == 2'b11; endproperty
	a_flow_rd: assert property (p_flow_rd) else $error("flow read not driven");
	property p_pipe_rd; (rd && m) ##1 m ##1 (!oen && m) |-> ##2 left_data_oe == 2'b11; endproperty
	a_pipe_rd: assert property (p_pipe_rd) else $error("pipelined read not driven");
	property p_pipe_late; (!any && m)[*2] ##1 (rd && m) ##1 m |=> left_data_oe == 2'b00; endproperty
	a_pipe_late: assert property (p_pipe_late) else $error("pipelined read came early");
	property p_lane_blk;
		!m ##1 (any && left_lower_lane_select_n && !m) ##1 !m |-> ##2 !left_data_oe[DPR_LOWER_LANE];
	endproperty
	a_lane_blk: assert property (p_lane_blk) else $error("blocked lane driven");
	property p_oe_blk; !m ##1 (any && !m) ##1 (oen && !m) |-> ##2 left_data_oe == 2'b00; endproperty
	a_oe_blk: assert property (p_oe_blk) else $error("drive without output enable");
	property p_resel; (!sel && m) ##1 (rd && m) ##1 m ##1 (!oen && m) |-> ##2 left_data_oe == 2'b11; endproperty
	a_resel: assert property (p_resel) else $error("no drive after reselect");
endmodule
bind dpr_top dpr_top_chk i_dpr_top_chk (.clk(clk), .reset(reset),
	.left_active_low_select_n(left_active_low_select_n), .left_active_high_select(left_active_high_select),
	.left_write_n(left_write_n), .left_output_enable_n(left_output_enable_n),
	.left_lower_lane_select_n(left_lower_lane_select_n), .left_upper_lane_select_n(left_upper_lane_select_n),
	.left_output_latency_select(left_output_latency_select), .left_data_oe(left_data_oe),
	.left_powered_down(left_powered_down));

// file: dv/tb.sv
// Self-checking bench for the dual-port burst RAM
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("Error %0t: got %h want %h", $time, g, e); end end
module tb;
	import dpr_pkg::*;
	localparam int N = 44;
	localparam logic [N-1:0] IDLE = {34'h0, 10'h1EF};
	logic          clk = 1'b0;
	logic          reset = 1'b1;
	logic [N-1:0]  req [2];
	logic [N-1:0]  pn [2];
	logic [17:0]   dout [2];
	logic [1:0]    doe [2];
	logic          pd [2];
	logic [17:0]   mem [logic [15:0]];
	logic [15:0]   cnt [2];
	logic [17:0]   sd [2][4];
	logic [1:0]    sl [2][4];
	logic [17:0]   wd [2];
	logic [1:0]    wl [2];
	logic [15:0]   wa [2];
	logic          lm [2];
	int            hold [2];
	int            seed = 37;
	int            errors = 0;
	int            comparisons = 0;
	int            cycles = 0;
	always #2 clk = ~clk;
	for (genvar p = 0; p < 2; p++) begin : g_host
		dpr_host i_dpr_host (.clk(clk), .reset(reset), .req(req[p]), .pins(pn[p]));
	end
	dpr_top i_dpr_top (.clk(clk), .reset(reset),
		.left_addr(pn[0][43:28]), .left_data_in(pn[0][27:10]),
		.left_addr_load_strobe_n(pn[0][0]), .left_burst_count_enable_n(pn[0][1]),
		.left_burst_count_clear_n(pn[0][2]), .left_active_low_select_n(pn[0][3]),
		.left_active_high_select(pn[0][4]), .left_write_n(pn[0][5]), .left_output_enable_n(pn[0][6]),
		.left_lower_lane_select_n(pn[0][7]), .left_upper_lane_select_n(pn[0][8]),
		.left_output_latency_select(pn[0][9]), .left_data_out(dout[0]), .left_data_oe(doe[0]),
		.left_powered_down(pd[0]), .right_addr(pn[1][43:28]), .right_data_in(pn[1][27:10]),
		.right_addr_load_strobe_n(pn[1][0]), .right_burst_count_enable_n(pn[1][1]),
		.right_burst_count_clear_n(pn[1][2]), .right_active_low_select_n(pn[1][3]),
		.right_active_high_select(pn[1][4]), .right_write_n(pn[1][5]), .right_output_enable_n(pn[1][6]),
		.right_lower_lane_select_n(pn[1][7]), .right_upper_lane_select_n(pn[1][8]),
		.right_output_latency_select(pn[1][9]), .right_data_out(dout[1]), .right_data_oe(doe[1]),
		.right_powered_down(pd[1]));
	// ====================
	// Reference model, fed from the pins as the device samples them
	always @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			logic [9:0] c;
			int k;
			c = pn[p][9:0];
			for (k = 0; k < 3; k++) begin
				sd[p][k] = sd[p][k+1];
				sl[p][k] = sl[p][k+1];
			end
			sl[p][3] = 2'b00;
			wl[p] = 2'b00;
			if (c[6])
				sl[p][1] = 2'b00;
			// A latency change leaves the output stage ambiguous for a few edges
			hold[p] = (reset || c[9] !== lm[p]) ? 4 : (hold[p] > 0 ? hold[p] - 1 : 0);
			lm[p] = c[9];
			if (reset)
				cnt[p] = 16'(DPR_CNT_RST);
			else begin
				cnt[p] = next_cnt(c, pn[p][43:28], cnt[p]);
				if (!c[3] && c[4] && c[5]) begin
					k = c[9] ? 3 : 2;
					sl[p][k] = ~c[8:7];
					sd[p][k] = mem[cnt[p]];
				end else if (!c[3] && c[4]) begin
					wa[p] = cnt[p];
					wd[p] = pn[p][27:10];
					wl[p] = ~c[8:7];
				end
			end
		end
		for (int p = 0; p < 2; p++) begin
			if (wl[p][0])
				mem[wa[p]][8:0] = wd[p][8:0];
			if (wl[p][1])
				mem[wa[p]][17:9] = wd[p][17:9];
		end
	end
	always @(negedge clk)
		for (int p = 0; p < 2; p++)
			if (!reset && hold[p] == 0) begin
				`CHK(doe[p], sl[p][0])
				if (sl[p][0][0]) `CHK(dout[p][8:0], sd[p][0][8:0])
				if (sl[p][0][1]) `CHK(dout[p][17:9], sd[p][0][17:9])
			end
	always @(negedge clk) begin
		cycles++;
		if (cycles > 4000) begin
			errors++;
			wrap_up();
		end
	end
	// ====================
	// Stimulus
	function automatic logic [9:0] cf(bit ld, bit cn, bit clr, bit [1:0] s, bit wr, bit oe, bit [1:0] ln, bit pp);
		return {pp, ~ln, ~oe, ~wr, s, ~clr, ~cn, ~ld};
	endfunction
	// Clear beats load, load beats count, the sum wraps at the top
	function automatic logic [15:0] next_cnt(logic [9:0] c, logic [15:0] a, logic [15:0] q);
		return !c[2] ? 16'h0000 : !c[0] ? a : !c[1] ? q + 16'h0001 : q;
	endfunction
	task automatic step(logic [N-1:0] l, logic [N-1:0] r);
		@(posedge clk);
		req[0] <= l;
		req[1] <= r;
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		logic [31:0]  r;
		logic [N-1:0] v [2];
		req[0] = IDLE;
		req[1] = IDLE;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		step(IDLE, IDLE);
		#1 `CHK({pd[0], pd[1]}, 2'b11)
		for (int i = 0; i < 4; i++)
			step(IDLE, {16'hFFFE, 18'($random(seed)), cf(i == 0, i != 0, 0, 2'b10, 1, 0, 2'b11, 0)});
		for (int i = 0; i < 256; i++)
			step({i == 0 ? 16'h0000 : 16'($random(seed)), 18'($random(seed)), cf(i == 0, i != 0, 0, 2'b10, 1, 0, 2'b11, 0)},
				{16'h0100, 18'($random(seed)), cf(i == 0, i != 0, 0, 2'b10, 1, 0, 2'b11, 0)});
		$display("Test burst fill done");
		for (int pp = 0; pp < 2; pp++) begin
			for (int i = 0; i < 400; i++) begin
				// Ports load from separate address windows (0x0000-0x007F left, 0x0100-0x017F right) so no write collides
				for (int p = 0; p < 2; p++) begin
					r = $random(seed);
					v[p] = {p ? 8'h01 : 8'h00, 1'b0, r[22:16], 18'($random(seed)), cf(r[0], r[1], p == 0 && r[5:2] == 0,
						r[9:6] == 0 ? r[24:23] : 2'b10, r[10], r[12:11] != 0, r[13] ? 2'b11 : r[15:14], pp)};
				end
				step(v[0], v[1]);
			end
			$display("Test random traffic mode %0d done", pp);
		end
		repeat (4) step(IDLE, IDLE);
		step({16'h0040, 18'h2A5A5, cf(1, 0, 0, 2'b10, 1, 0, 2'b11, 0)}, IDLE);
		step({16'h0040, 18'h15555, cf(1, 0, 0, 2'b10, 1, 0, 2'b01, 0)},
			{16'h0040, 18'h00000, cf(1, 0, 0, 2'b10, 0, 0, 2'b11, 0)});
		for (int i = 0; i < 4; i++)
			step({16'h0040, 18'h00000, cf(i == 0, 0, 0, 2'b10, 0, 0, 2'b11, 0)},
				{16'hFFFE, 18'h00000, cf(i == 0, i != 0, 0, 2'b10, 0, 0, 2'b11, 0)});
		step(IDLE, {16'h0123, 18'h00000, cf(1, 1, 1, 2'b10, 0, 0, 2'b11, 0)});
		step(IDLE, {16'h0123, 18'h00000, cf(1, 1, 0, 2'b10, 0, 0, 2'b11, 0)});
		repeat (6) step(IDLE, IDLE);
		$display("Test directed cases done");
		wrap_up();
	end
endmodule
